// ===== rtl/otg_control_status.sv
/*
 * Control and status logic of a dual-role USB module: cable and supply
 * status, line stability, resistor enables, power and suspend handshake,
 * last transfer record and the module control bits, over AHB-Lite.
 * Assumes all pin inputs synchronous to hclk and a single bus master.
 */
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "otg_ctl_defs.svh"

module otg_control_status #(
	parameter int unsigned STABLE_CYCLES =
		`STABLE_TIME_NS / `CLK_PERIOD_NS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic id_pin,
	input wire logic se0_in,
	input wire logic j_state_in,
	input wire logic sess_valid_in,
	input wire logic sess_end_in,
	input wire logic vbus_valid_in,
	input wire logic bus_activity,
	input wire logic setup_token,
	input wire logic xfer_done,
	input wire logic [3:0] xfer_endpoint,
	input wire logic xfer_tx,
	input wire logic xfer_odd,
	output logic dplus_pullup_enable,
	output logic dminus_pullup_enable,
	output logic dplus_pulldown_enable,
	output logic dminus_pulldown_enable,
	output logic vbus_power_on,
	output logic vbus_charge_select,
	output logic vbus_discharge,
	output logic module_enable,
	output logic usb_clk_enable,
	output logic xcvr_low_power,
	output logic packet_hold,
	output logic resume_drive,
	output logic device_attach,
	output logic host_mode,
	output logic bank_pointer_reset
);
	logic wr_en;
	logic [2:0] wr_index, rd_index;
	logic [7:0] wr_data;
	logic [15:0] rd_value;
	logic line_stable_flag;

	////////////////////////////////////////////////////////////////////
	// Bus front end and line stability timer.

	ahb_reg_port bus_port (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hready(hready),
		.hwdata(hwdata),
		.rd_value(rd_value),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wr_en(wr_en),
		.wr_index(wr_index),
		.wr_data(wr_data),
		.rd_index(rd_index)
	);

	line_stable_timer #(
		.STABLE_CYCLES(STABLE_CYCLES)
	) stable_timer (
		.hclk(hclk),
		.hresetn(hresetn),
		.se0(se0_in),
		.j_state(j_state_in),
		.stable(line_stable_flag)
	);

	function automatic logic hit(input logic en, input logic [2:0] a,
			input logic [2:0] b);
		hit = en && (a == b);
	endfunction : hit

	////////////////////////////////////////////////////////////////////
	// Resistor and supply control register.

	logic [7:0] res_ctl_reg, res_ctl_next;

	always_comb begin
		res_ctl_next = res_ctl_reg;
		if (hit(wr_en, wr_index, `IDX_RESISTOR_CTL)) begin
			res_ctl_next = wr_data;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_ctl_reg <= `CTL_RESET;
		end else begin
			res_ctl_reg <= res_ctl_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Power and suspend control.

	logic pending_reg, pending_next;
	logic guard_reg, guard_next;
	logic suspend_reg, suspend_next;
	logic power_reg, power_next;

	always_comb begin
		guard_next = guard_reg;
		suspend_next = suspend_reg;
		power_next = power_reg;
		// Bus activity wakes a suspended module.
		if (suspend_reg && bus_activity) begin
			suspend_next = 1'b0;
		end
		if (hit(wr_en, wr_index, `IDX_POWER_CTL)) begin
			guard_next = wr_data[`B_GUARD];
			suspend_next = wr_data[`B_SUSPEND];
			power_next = wr_data[`B_POWER];
		end
		pending_next = guard_reg && bus_activity;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pending_reg <= 1'b0;
			guard_reg <= 1'b0;
			suspend_reg <= 1'b0;
			power_reg <= 1'b0;
		end else begin
			pending_reg <= pending_next;
			guard_reg <= guard_next;
			suspend_reg <= suspend_next;
			power_reg <= power_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Last transfer record.

	logic [3:0] ep_reg, ep_next;
	logic dir_reg, dir_next;
	logic odd_reg, odd_next;

	always_comb begin
		ep_next = ep_reg;
		dir_next = dir_reg;
		odd_next = odd_reg;
		if (xfer_done) begin
			ep_next = xfer_endpoint;
			dir_next = xfer_tx;
			odd_next = xfer_odd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ep_reg <= `EP_RESET;
			dir_reg <= 1'b0;
			odd_reg <= 1'b0;
		end else begin
			ep_reg <= ep_next;
			dir_reg <= dir_next;
			odd_reg <= odd_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Module control register.

	logic packet_disable_reg, packet_disable_next;
	logic host_reg, host_next;
	logic resume_reg, resume_next;
	logic ppbrst_reg, ppbrst_next;
	logic moden_reg, moden_next;

	always_comb begin
		packet_disable_next = packet_disable_reg;
		host_next = host_reg;
		resume_next = resume_reg;
		ppbrst_next = ppbrst_reg;
		moden_next = moden_reg;
		if (hit(wr_en, wr_index, `IDX_MODULE_CTL)) begin
			packet_disable_next = wr_data[`B_PACKET_DISABLE];
			host_next = wr_data[`B_HOST];
			resume_next = wr_data[`B_RESUME];
			ppbrst_next = wr_data[`B_PPBRST];
			moden_next = wr_data[`B_MODEN];
		end
		// A SETUP arriving with a clearing write still sets the bit.
		if (setup_token && !host_reg) begin
			packet_disable_next = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			packet_disable_reg <= 1'b0;
			host_reg <= 1'b0;
			resume_reg <= 1'b0;
			ppbrst_reg <= 1'b0;
			moden_reg <= 1'b0;
		end else begin
			packet_disable_reg <= packet_disable_next;
			host_reg <= host_next;
			resume_reg <= resume_next;
			ppbrst_reg <= ppbrst_next;
			moden_reg <= moden_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin controls and read-back.

	logic otg_en;
	assign otg_en = res_ctl_reg[`B_OTG_EN];

	always_comb begin
		if (otg_en) begin
			dplus_pullup_enable = res_ctl_reg[`B_DP_PU];
			dminus_pullup_enable = res_ctl_reg[`B_DM_PU];
			dplus_pulldown_enable = res_ctl_reg[`B_DP_PD];
			dminus_pulldown_enable = res_ctl_reg[`B_DM_PD];
		end else begin
			// Without OTG a device presents a full-speed D+ pull-up.
			dplus_pullup_enable = power_reg && moden_reg &&
				!host_reg;
			dminus_pullup_enable = 1'b0;
			dplus_pulldown_enable = 1'b0;
			dminus_pulldown_enable = 1'b0;
		end
		if (host_reg) begin
			dplus_pullup_enable = 1'b0;
			dminus_pullup_enable = 1'b0;
			dplus_pulldown_enable = 1'b1;
			dminus_pulldown_enable = 1'b1;
		end
	end

	assign vbus_power_on = res_ctl_reg[`B_VBUS_ON];
	assign vbus_charge_select = res_ctl_reg[`B_VBUS_CHG];
	assign vbus_discharge = res_ctl_reg[`B_VBUS_DIS];
	assign module_enable = power_reg;
	assign usb_clk_enable = power_reg && !suspend_reg;
	assign xcvr_low_power = suspend_reg || !power_reg;
	assign packet_hold = packet_disable_reg && !host_reg;
	assign resume_drive = resume_reg && power_reg;
	assign device_attach = power_reg && moden_reg && !host_reg;
	assign host_mode = host_reg;
	assign bank_pointer_reset = ppbrst_reg;

	always_comb begin
		rd_value = `WORD_ZERO;
		case (rd_index)
			`IDX_LINE_STATUS: begin
				rd_value[`B_ID] = id_pin;
				rd_value[`B_LSTABLE] = line_stable_flag;
				rd_value[`B_SESS_VLD] = sess_valid_in;
				rd_value[`B_SESS_END] = sess_end_in;
				rd_value[`B_VBUS_VLD] = vbus_valid_in;
			end
			`IDX_RESISTOR_CTL: begin
				rd_value[7:0] = res_ctl_reg;
			end
			`IDX_POWER_CTL: begin
				rd_value[`B_PENDING] = pending_reg;
				rd_value[`B_GUARD] = guard_reg;
				rd_value[`B_SUSPEND] = suspend_reg;
				rd_value[`B_POWER] = power_reg;
			end
			`IDX_XFER_STATUS: begin
				rd_value[`B_EP_MSB:`B_EP_LSB] = ep_reg;
				rd_value[`B_DIR] = dir_reg;
				rd_value[`B_ODD] = odd_reg;
			end
			`IDX_MODULE_CTL: begin
				rd_value[`B_J_STATE_FLAG] = j_state_in;
				rd_value[`B_SE0] = se0_in;
				rd_value[`B_PACKET_DISABLE] = packet_disable_reg;
				rd_value[`B_HOST] = host_reg;
				rd_value[`B_RESUME] = resume_reg;
				rd_value[`B_PPBRST] = ppbrst_reg;
				rd_value[`B_MODEN] = moden_reg;
			end
			default: begin
				rd_value = `WORD_ZERO;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_power_clear_write;
		hit(wr_en, wr_index, `IDX_POWER_CTL) && !wr_data[`B_POWER];
	endsequence

	a_host_pulldowns: assert property (
		host_reg |-> dplus_pulldown_enable && dminus_pulldown_enable)
		else $error("host mode without both pull-downs");
	a_line_change_clears: assert property (
		({se0_in, j_state_in} != $past({se0_in, j_state_in}))
		|=> !line_stable_flag [*2])
		else $error("line-stable flag set after a line change");
	a_setup_sets_packet_disable: assert property (
		setup_token && !host_reg |=> packet_disable_reg && packet_hold)
		else $error("SETUP did not set packet disable");
	a_xfer_record: assert property (
		xfer_done |=> ep_reg == $past(xfer_endpoint) &&
		dir_reg == $past(xfer_tx) && odd_reg == $past(xfer_odd))
		else $error("last transfer record not loaded");
	a_suspend_gates_clk: assert property (
		suspend_reg |-> !usb_clk_enable && xcvr_low_power)
		else $error("suspend left the USB clock running");
	a_pending_needs_guard: assert property (
		!guard_reg |=> !pending_reg)
		else $error("activity pending without sleep guard");
	a_power_clear: assert property (
		s_power_clear_write |=> !module_enable && !usb_clk_enable)
		else $error("module still enabled after power clear");
	a_otg_off_pullup: assert property (
		!otg_en && !host_reg |-> dplus_pullup_enable ==
		(power_reg && moden_reg) && !dminus_pullup_enable)
		else $error("pull-up not derived from enables");
	a_resistor_bits: assert property (
		otg_en && !host_reg |-> {dplus_pullup_enable,
		dminus_pullup_enable, dplus_pulldown_enable,
		dminus_pulldown_enable} == res_ctl_reg[`B_DP_PU:`B_DM_PD])
		else $error("resistor enables differ from control bits");
	a_read_wait: assert property (
		hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1
		hreadyout)
		else $error("read data phase not one wait state");
endmodule : otg_control_status
`default_nettype wire

// ===== rtl/otg_ctl_defs.svh
/*
 * Register indices, field positions, reset values and timing figures of
 * the OTG control and status block.
 * Assumes it is included by bare name from the files that need it.
 */
`ifndef OTG_CTL_DEFS_SVH
`define OTG_CTL_DEFS_SVH

// Register indices; the byte address is four times the index.
`define IDX_LINE_STATUS 3'h0
`define IDX_RESISTOR_CTL 3'h1
`define IDX_POWER_CTL 3'h2
`define IDX_XFER_STATUS 3'h3
`define IDX_MODULE_CTL 3'h4
`define IDX_LAST 3'h4

// Line and supply status fields.
`define B_ID 7
`define B_LSTABLE 5
`define B_SESS_VLD 3
`define B_SESS_END 2
`define B_VBUS_VLD 0

// Resistor and supply control fields.
`define B_DP_PU 7
`define B_DM_PU 6
`define B_DP_PD 5
`define B_DM_PD 4
`define B_VBUS_ON 3
`define B_OTG_EN 2
`define B_VBUS_CHG 1
`define B_VBUS_DIS 0

// Power and suspend control fields.
`define B_PENDING 7
`define B_GUARD 4
`define B_SUSPEND 1
`define B_POWER 0

// Last transfer status fields.
`define B_EP_MSB 7
`define B_EP_LSB 4
`define B_DIR 3
`define B_ODD 2

// Module control fields.
`define B_J_STATE_FLAG 7
`define B_SE0 6
`define B_PACKET_DISABLE 5
`define B_HOST 3
`define B_RESUME 2
`define B_PPBRST 1
`define B_MODEN 0

`define CTL_RESET 8'h00
`define EP_RESET 4'h0
`define WORD_ZERO 16'h0000

// Timing.
`define CLK_PERIOD_NS 5
`define STABLE_TIME_NS 1000000

`endif

// ===== rtl/otg_ctl_pkg.sv
/*
 * Types shared by the OTG control and status block.
 * Assumes nothing of its surroundings.
 */
package otg_ctl_pkg;
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_WRITE,
		PH_READ_WAIT,
		PH_READ_DONE
	} bus_phase_t;

	typedef logic [15:0] reg_word_t;
endpackage : otg_ctl_pkg

// ===== rtl/line_stable_timer.sv
/*
 * Watches the bus line state and flags it once it has not changed for a
 * whole stability interval.
 * Assumes line inputs synchronous to hclk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "otg_ctl_defs.svh"

module line_stable_timer #(
	parameter int unsigned STABLE_CYCLES =
		`STABLE_TIME_NS / `CLK_PERIOD_NS
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic se0,
	input wire logic j_state,
	output logic stable
);
	localparam int W = $clog2(STABLE_CYCLES + 1);

	logic [1:0] last_reg, last_next;
	logic [W-1:0] cnt_reg, cnt_next;
	logic stable_reg, stable_next;

	always_comb begin
		last_next = {se0, j_state};
		cnt_next = cnt_reg;
		if (last_next != last_reg) begin
			cnt_next = '0;
		end else if (cnt_reg != W'(STABLE_CYCLES)) begin
			cnt_next = cnt_reg + 1'b1;
		end
		stable_next = (last_next == last_reg) &&
			(cnt_reg == W'(STABLE_CYCLES));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_reg <= 2'h0;
			cnt_reg <= '0;
			stable_reg <= 1'b0;
		end else begin
			last_reg <= last_next;
			cnt_reg <= cnt_next;
			stable_reg <= stable_next;
		end
	end

	assign stable = stable_reg;
endmodule : line_stable_timer
`default_nettype wire

// ===== rtl/ahb_reg_port.sv
/*
 * AHB-Lite slave front end: decodes word registers, gives writes a
 * zero-wait data phase and reads one wait state.
 * Assumes it is the only slave, so hready equals its own hreadyout.
 */
`timescale 1ns/10ps
`default_nettype none
`include "otg_ctl_defs.svh"

module ahb_reg_port (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [15:0] rd_value,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic wr_en,
	output logic [2:0] wr_index,
	output logic [7:0] wr_data,
	output logic [2:0] rd_index
);
	otg_ctl_pkg::bus_phase_t phase_reg, phase_next;
	logic [2:0] idx_reg, idx_next;
	logic mapped_reg, mapped_next;
	logic [31:0] hrdata_reg, hrdata_next;

	always_comb begin
		phase_next = otg_ctl_pkg::PH_IDLE;
		idx_next = idx_reg;
		mapped_next = mapped_reg;
		hrdata_next = hrdata_reg;
		hreadyout = 1'b1;
		wr_en = 1'b0;
		case (phase_reg)
			otg_ctl_pkg::PH_WRITE: begin
				wr_en = mapped_reg;
			end
			otg_ctl_pkg::PH_READ_WAIT: begin
				hreadyout = 1'b0;
				hrdata_next = {`WORD_ZERO,
					mapped_reg ? rd_value : `WORD_ZERO};
				phase_next = otg_ctl_pkg::PH_READ_DONE;
			end
			otg_ctl_pkg::PH_READ_DONE: begin
				hreadyout = 1'b1;
			end
			default: begin
				hreadyout = 1'b1;
			end
		endcase
		// Unmapped addresses answer OKAY, read zero and ignore writes.
		if (hsel && hready && htrans[1]) begin
			phase_next = hwrite ? otg_ctl_pkg::PH_WRITE :
				otg_ctl_pkg::PH_READ_WAIT;
			idx_next = haddr[4:2];
			mapped_next = (haddr[31:5] == 27'h0000000) &&
				(haddr[4:2] <= `IDX_LAST);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg <= otg_ctl_pkg::PH_IDLE;
			idx_reg <= 3'h0;
			mapped_reg <= 1'b0;
			hrdata_reg <= 32'h00000000;
		end else begin
			phase_reg <= phase_next;
			idx_reg <= idx_next;
			mapped_reg <= mapped_next;
			hrdata_reg <= hrdata_next;
		end
	end

	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign wr_index = idx_reg;
	assign wr_data = hwdata[7:0];
	assign rd_index = idx_reg;
endmodule : ahb_reg_port
`default_nettype wire

// ===== dv/usb_far_end.sv
/*
 * Far-side model: cable partner and transfer engine feeding the line,
 * supply, activity and transfer inputs of the block.
 * Assumes the bench calls its tasks and hclk is the block's clock.
 */
`timescale 1ns/10ps
`default_nettype none

module usb_far_end (
	input wire logic hclk,
	output logic id_pin,
	output logic se0_in,
	output logic j_state_in,
	output logic sess_valid_in,
	output logic sess_end_in,
	output logic vbus_valid_in,
	output logic bus_activity,
	output logic setup_token,
	output logic xfer_done,
	output logic [3:0] xfer_endpoint,
	output logic xfer_tx,
	output logic xfer_odd
);
	initial begin
		{id_pin, se0_in, j_state_in, sess_valid_in} = 4'h8;
		{sess_end_in, vbus_valid_in, bus_activity, setup_token} = 4'h0;
		{xfer_done, xfer_endpoint, xfer_tx, xfer_odd} = 7'h00;
	end

	task automatic set_line(input logic s, input logic j);
		@(posedge hclk);
		se0_in <= s;
		j_state_in <= j;
	endtask : set_line

	task automatic set_supply(input logic [3:0] v);
		@(posedge hclk);
		{id_pin, sess_valid_in, sess_end_in, vbus_valid_in} <= v;
	endtask : set_supply

	task automatic set_activity(input logic a);
		@(posedge hclk);
		bus_activity <= a;
	endtask : set_activity

	task automatic send_setup();
		@(posedge hclk);
		setup_token <= 1'b1;
		@(posedge hclk);
		setup_token <= 1'b0;
	endtask : send_setup

	// Transfer fields are only valid with the strobe; afterwards they flip.
	task automatic send_xfer(input logic [3:0] ep, input logic tx,
			input logic odd);
		@(posedge hclk);
		{xfer_done, xfer_endpoint, xfer_tx, xfer_odd} <= {1'b1, ep, tx, odd};
		@(posedge hclk);
		{xfer_done, xfer_endpoint, xfer_tx, xfer_odd} <= {1'b0, ~ep, ~tx, ~odd};
	endtask : send_xfer
endmodule : usb_far_end

`default_nettype wire

// ===== dv/tb_top.sv
/*
 * Self-checking bench for the OTG control and status block.
 * Assumes the block is the only AHB-Lite slave, so hready is hreadyout.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	localparam logic [31:0] all_bits = 32'hffffffff;
	logic hclk = 1'b0;
	logic hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic id_pin, se0_in, j_state_in, sess_valid_in, sess_end_in;
	logic vbus_valid_in, bus_activity, setup_token, xfer_done, xfer_tx;
	logic xfer_odd;
	logic [3:0] xfer_endpoint, pins;
	logic dplus_pullup_enable, dminus_pullup_enable, dplus_pulldown_enable;
	logic dminus_pulldown_enable, vbus_power_on, vbus_charge_select;
	logic vbus_discharge, module_enable, usb_clk_enable, xcvr_low_power;
	logic packet_hold, resume_drive, device_attach, host_mode;
	logic bank_pointer_reset;
	int fail_count = 0;
	int n_compared = 0;

	assign pins = {dplus_pullup_enable, dminus_pullup_enable,
		dplus_pulldown_enable, dminus_pulldown_enable};

	always #2.5 hclk = ~hclk;

	otg_control_status #(.STABLE_CYCLES(20)) otg_control_status_i (.hclk,
		.hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .id_pin,
		.se0_in, .j_state_in, .sess_valid_in, .sess_end_in, .vbus_valid_in,
		.bus_activity, .setup_token, .xfer_done, .xfer_endpoint, .xfer_tx,
		.xfer_odd, .dplus_pullup_enable, .dminus_pullup_enable,
		.dplus_pulldown_enable, .dminus_pulldown_enable, .vbus_power_on,
		.vbus_charge_select, .vbus_discharge, .module_enable, .usb_clk_enable,
		.xcvr_low_power, .packet_hold, .resume_drive, .device_attach,
		.host_mode, .bank_pointer_reset);

	usb_far_end usb_far_end_i (.hclk, .id_pin, .se0_in, .j_state_in,
		.sess_valid_in, .sess_end_in, .vbus_valid_in, .bus_activity,
		.setup_token, .xfer_done, .xfer_endpoint, .xfer_tx, .xfer_odd);

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string m);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	// Ready and read data are sampled mid-cycle, where they are settled.
	task automatic wait_rdy(output logic [31:0] d);
		int n;
		logic r;
		n = 0;
		r = 1'b0;
		while (r !== 1'b1) begin
			@(negedge hclk);
			r = hreadyout;
			d = hrdata;
			@(posedge hclk);
			n++;
			if (n > 40) begin
				fail_count++;
				$display("MISMATCH %0t bus hang", $time);
				wrap_up();
			end
		end
	endtask : wait_rdy

	task automatic bus(input logic wr, input logic [2:0] idx,
			input logic [7:0] wd, output logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {27'h0, idx, 2'h0};
		hwrite <= wr;
		wait_rdy(d);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		wait_rdy(d);
	endtask : bus

	task automatic wr(input logic [2:0] idx, input logic [7:0] v);
		logic [31:0] d;
		bus(1'b1, idx, v, d);
	endtask : wr

	task automatic rd(input logic [2:0] idx, input logic [31:0] mask,
			input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, idx, 8'h00, d);
		chk(d & mask, exp, "register read");
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		@(negedge hclk);
		chk({module_enable, xcvr_low_power, hresp},
			3'h2, "reset");
		rd(3'h1, all_bits, 32'h0);
		rd(3'h2, all_bits, 32'h0);
		rd(3'h3, all_bits, 32'h0);
		rd(3'h4, all_bits, 32'h0);
		wr(3'h6, 8'hff);
		rd(3'h6, all_bits, 32'h0);
	endtask : t_reset

	task automatic t_line();
		usb_far_end_i.set_line(1'b0, 1'b1);
		repeat (5) @(posedge hclk);
		rd(3'h0, 32'h20, 32'h00);
		repeat (30) @(posedge hclk);
		rd(3'h0, 32'h20, 32'h20);
		usb_far_end_i.set_line(1'b1, 1'b0);
		rd(3'h0, 32'h20, 32'h00);
		rd(3'h4, 32'hc0, 32'h40);
	endtask : t_line

	task automatic t_supply();
		logic [3:0] v [3] = '{4'h2, 4'hc, 4'h5};
		logic [31:0] e;
		for (int i = 0; i < 3; i++) begin
			usb_far_end_i.set_supply(v[i]);
			e = {24'h0, v[i][3], 3'h0, v[i][2:1], 1'b0, v[i][0]};
			rd(3'h0, 32'hdf, e);
		end
	endtask : t_supply

	task automatic t_pins();
		for (int i = 0; i < 16; i++) begin
			wr(3'h1, {i[3:0], 4'h4});
			@(negedge hclk);
			chk(pins, i, "pin enables");
		end
		rd(3'h1, all_bits, 32'hf4);
		wr(3'h4, 8'h08);
		@(negedge hclk);
		chk({pins, host_mode}, 5'h07, "host pulls");
		wr(3'h4, 8'h00);
		wr(3'h1, 8'h0b);
		wr(3'h2, 8'h01);
		wr(3'h4, 8'h01);
		@(negedge hclk);
		chk({pins, device_attach, vbus_power_on, vbus_charge_select,
			vbus_discharge}, 8'h8f, "attached");
		wr(3'h4, 8'h00);
		@(negedge hclk);
		chk({pins, device_attach}, 5'h00, "detached");
	endtask : t_pins

	task automatic t_power();
		@(negedge hclk);
		chk({module_enable, usb_clk_enable, xcvr_low_power},
			3'h6, "on");
		usb_far_end_i.set_activity(1'b1);
		rd(3'h2, all_bits, 32'h01);
		wr(3'h2, 8'h11);
		rd(3'h2, all_bits, 32'h91);
		usb_far_end_i.set_activity(1'b0);
		wr(3'h2, 8'h13);
		@(negedge hclk);
		chk({usb_clk_enable, xcvr_low_power}, 2'h1, "suspended");
		usb_far_end_i.set_activity(1'b1);
		repeat (3) @(posedge hclk);
		rd(3'h2, all_bits, 32'h91);
		usb_far_end_i.set_activity(1'b0);
		wr(3'h2, 8'h01);
	endtask : t_power

	task automatic t_xfer();
		logic [5:0] x [3] = '{6'h3f, 6'h00, 6'h2a};
		for (int i = 0; i < 3; i++) begin
			usb_far_end_i.send_xfer(x[i][5:2], x[i][1], x[i][0]);
			rd(3'h3, all_bits, {24'h0, x[i], 2'h0});
		end
	endtask : t_xfer

	task automatic t_modctl();
		usb_far_end_i.send_setup();
		rd(3'h4, 32'h3f, 32'h20);
		@(negedge hclk);
		chk(packet_hold, 1'b1, "packet hold");
		wr(3'h4, 8'h0e);
		usb_far_end_i.send_setup();
		rd(3'h4, 32'h3f, 32'h0e);
		@(negedge hclk);
		chk({packet_hold, resume_drive, bank_pointer_reset},
			3'h3, "resume");
		wr(3'h4, 8'h00);
		wr(3'h1, 8'h00);
		wr(3'h2, 8'h00);
		@(negedge hclk);
		chk({module_enable, resume_drive, xcvr_low_power},
			3'h1, "off");
	endtask : t_modctl

	////////////////////////////////////////////////////////////////////////
	initial begin
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_line();
		t_supply();
		t_pins();
		t_power();
		t_xfer();
		t_modctl();
		wrap_up();
	end
endmodule : tb_top

`default_nettype wire
